// ==== pkg/sclk_div_pkg.sv ====
// package: constants and types for the serial clock divider
`default_nettype none

package sclk_div_pkg;

	// ----------------------------------------
	// control register layout
	// ----------------------------------------
	localparam int unsigned MOD_W        = 8;
	localparam int unsigned MOD_LSB      = 0;
	localparam int unsigned BYPASS_BIT   = 8;
	localparam int unsigned CTRL_W       = 9;
	localparam logic [7:0]  MOD_RESET    = 8'hff;
	localparam logic        BYPASS_RESET = 1'b0;

	// ----------------------------------------
	// timing constants
	// ----------------------------------------
	localparam int unsigned PRESCALE_DIV = 8;
	localparam logic [2:0]  PRESCALE_MAX = 3'h7;
	localparam int unsigned SCL_EXTRA_TC = 3;
	localparam int unsigned FIXED_NS     = 45;
	localparam int unsigned CLK_NS       = 10;
	// fixed delay rounded up to whole core cycles
	localparam int unsigned FIXED_CYC    = (FIXED_NS + CLK_NS - 1) / CLK_NS;
	// four bits: three plus five core cycles does not fit in three
	localparam logic [3:0]  TAIL_CYC     = 4'(SCL_EXTRA_TC + FIXED_CYC);
	localparam logic [7:0]  MOD_MIN_I2C  = 8'h02;

	typedef struct packed {
		logic       prescaler_bypass;
		logic [7:0] clock_divider_modulus;
	} clk_ctrl_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DIV  = 3'b010,
		ST_TAIL = 3'b100
	} phase_e;

endpackage

`default_nettype wire

// ==== rtl/i2c_serial_clock_divider.sv ====
// module: serial clock divider for the host interface in bus master mode
`timescale 1ns/1ns
`default_nettype none

// Contract
// [RULE1] programmed period is Tc*2*(modulus+1)*(8 or 1 when bypassed)
// [RULE2] bypass bit clear inserts divide-by-eight prescaler, set skips it
// [RULE3] modulus accepts 00 through ff, dividing by one to 256
// [RULE4] software uses modulus at least 02 with bypass, six core cycles minimum
// [RULE5] master SCL period is programmed period plus three Tc plus 45 ns; code rounds 45 ns up to five core cycles (50 ns)
// [RULE6] control register written by host core, applies from next SCL period
module i2c_serial_clock_divider (
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    enable,
	input  wire logic                    ctrl_we,
	input  wire sclk_div_pkg::clk_ctrl_s ctrl_wdata,
	output var  sclk_div_pkg::clk_ctrl_s ctrl_rdata,
	output var  logic                    scl_out,
	output var  logic                    period_pulse,
	output var  logic                    config_below_min
);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	sclk_div_pkg::clk_ctrl_s ctrl_q, ctrl_d;
	sclk_div_pkg::clk_ctrl_s act_q, act_d;

	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_we) begin
			ctrl_d = ctrl_wdata; // RULE6
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= '{prescaler_bypass: sclk_div_pkg::BYPASS_RESET,
				clock_divider_modulus: sclk_div_pkg::MOD_RESET};
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	assign ctrl_rdata = ctrl_q;

	// ----------------------------------------
	// divider state
	// ----------------------------------------
	sclk_div_pkg::phase_e st_q, st_d;
	logic [2:0] pre_q, pre_d;
	logic [7:0] mod_q, mod_d;
	logic       half_q, half_d;
	logic [3:0] tail_q, tail_d;
	logic       scl_q, scl_d;
	logic       pulse_q, pulse_d;
	logic       pre_tick;

	// prescaler tick every cycle when bypassed, else every eighth
	assign pre_tick = act_q.prescaler_bypass || (pre_q == sclk_div_pkg::PRESCALE_MAX); // RULE2

	always_comb begin
		st_d    = st_q;
		pre_d   = pre_q;
		mod_d   = mod_q;
		half_d  = half_q;
		tail_d  = tail_q;
		scl_d   = scl_q;
		pulse_d = 1'b0;
		act_d   = act_q;
		case (st_q)
			sclk_div_pkg::ST_IDLE: begin
				scl_d = 1'b1;
				if (enable) begin
					act_d  = ctrl_q; // RULE6
					st_d   = sclk_div_pkg::ST_DIV;
					pre_d  = 3'h0;
					mod_d  = 8'h00;
					half_d = 1'b0;
					scl_d  = 1'b0;
				end
			end
			sclk_div_pkg::ST_DIV: begin
				pre_d = act_q.prescaler_bypass ? 3'h0 : 3'(pre_q + 3'h1); // RULE2
				if (pre_tick) begin
					if (mod_q == act_q.clock_divider_modulus) begin // RULE3
						mod_d = 8'h00;
						if (half_q) begin
							// two halves of (modulus+1) ticks each
							st_d   = sclk_div_pkg::ST_TAIL; // RULE1
							tail_d = 4'h1;
							half_d = 1'b0;
						end else begin
							half_d = 1'b1;
							scl_d  = 1'b1;
						end
					end else begin
						mod_d = 8'(mod_q + 8'h01);
					end
				end
			end
			sclk_div_pkg::ST_TAIL: begin
				// fixed pad approximates core and pad delay of the period
				if (tail_q == sclk_div_pkg::TAIL_CYC) begin // RULE5
					pulse_d = 1'b1;
					act_d   = ctrl_q; // RULE6
					pre_d   = 3'h0;
					if (enable) begin
						st_d  = sclk_div_pkg::ST_DIV;
						scl_d = 1'b0;
					end else begin
						st_d = sclk_div_pkg::ST_IDLE;
					end
				end else begin
					tail_d = 4'(tail_q + 4'h1);
				end
			end
			default: begin
				st_d  = sclk_div_pkg::ST_IDLE;
				scl_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q    <= sclk_div_pkg::ST_IDLE;
			pre_q   <= 3'h0;
			mod_q   <= 8'h00;
			half_q  <= 1'b0;
			tail_q  <= 4'h0;
			scl_q   <= 1'b1;
			pulse_q <= 1'b0;
			act_q   <= '{prescaler_bypass: sclk_div_pkg::BYPASS_RESET,
				clock_divider_modulus: sclk_div_pkg::MOD_RESET};
		end else begin
			st_q    <= st_d;
			pre_q   <= pre_d;
			mod_q   <= mod_d;
			half_q  <= half_d;
			tail_q  <= tail_d;
			scl_q   <= scl_d;
			pulse_q <= pulse_d;
			act_q   <= act_d;
		end
	end

	assign scl_out      = scl_q;
	assign period_pulse = pulse_q;
	// flag for software, the divider still runs at any setting
	assign config_below_min = ctrl_q.clock_divider_modulus < sclk_div_pkg::MOD_MIN_I2C; // RULE4

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// cycles since the last period boundary
	logic [15:0] per_cnt_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			per_cnt_q <= 16'h0000;
		end else if (pulse_d || st_q == sclk_div_pkg::ST_IDLE) begin
			per_cnt_q <= 16'h0001;
		end else begin
			per_cnt_q <= 16'(per_cnt_q + 16'h0001);
		end
	end

	function automatic logic [15:0] exp_period(sclk_div_pkg::clk_ctrl_s c);
		logic [15:0] base;
		base = 16'(2 * (32'(c.clock_divider_modulus) + 1));
		if (!c.prescaler_bypass) begin
			base = 16'(base * 16'(sclk_div_pkg::PRESCALE_DIV));
		end
		return 16'(base + 16'(sclk_div_pkg::TAIL_CYC) + 16'h0001);
	endfunction

	AST_PERIOD_LEN: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
		(st_q == sclk_div_pkg::ST_DIV && !half_q && half_d)
		|-> 16'(per_cnt_q << 1) == 16'(exp_period(act_q) - 16'(sclk_div_pkg::TAIL_CYC) - 16'h0001))
		else $error("scl low time differs from half the programmed period");

	AST_PERIOD_EXACT: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
		(pulse_d && st_q == sclk_div_pkg::ST_TAIL && $past(st_q) != sclk_div_pkg::ST_IDLE
			&& per_cnt_q != 16'h0001)
		|-> per_cnt_q == 16'(exp_period(act_q) - 16'h0001))
		else $error("scl period differs from programmed period plus tail");

	AST_BYPASS_PRE: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
		act_q.prescaler_bypass |-> pre_q == 3'h0)
		else $error("prescaler counted while bypassed");

	AST_MOD_RANGE: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
		st_q == sclk_div_pkg::ST_DIV |-> mod_q <= act_q.clock_divider_modulus)
		else $error("modulus counter ran past modulus");

	AST_HOLD_CFG: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
		(st_q == sclk_div_pkg::ST_DIV && $past(st_q) == sclk_div_pkg::ST_DIV) |-> $stable(act_q))
		else $error("active setting changed inside a period");

	AST_MIN_FLAG: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
		ctrl_q.clock_divider_modulus >= 8'h02 |-> !config_below_min)
		else $error("minimum flag raised for legal modulus");

endmodule // i2c_serial_clock_divider

`default_nettype wire

// ==== testbench/scl_listener.sv ====
// bus-side listener: measures scl low time and fall-to-fall period
`timescale 1ns/1ns
`default_nettype none

module scl_listener (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        scl,
	output var  logic [15:0] low_cycles,
	output var  logic [15:0] period_cycles
);
	logic [15:0] low_n;
	logic [15:0] per_n;
	logic        scl_prev;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_n = '0;
			per_n = '0;
			scl_prev = 1'b1;
			low_cycles = '0;
			period_cycles = '0;
		end else begin
			per_n = per_n + 16'h1;
			if (!scl) low_n = low_n + 16'h1;
			if (scl_prev && !scl) begin
				period_cycles = per_n - 16'h1;
				per_n = 16'h1;
				low_n = 16'h1;
			end
			if (!scl_prev && scl) low_cycles = low_n;
			scl_prev = scl;
		end
	end
endmodule // scl_listener

`default_nettype wire

// ==== testbench/i2c_serial_clock_divider_tb.sv ====
// self-checking testbench for the serial clock divider
`timescale 1ns/1ns
`default_nettype none

module i2c_serial_clock_divider_tb;
	logic                    ref_clk, rst, enable, ctrl_we, scl_out, period_pulse, below_min;
	sclk_div_pkg::clk_ctrl_s ctrl_wdata, ctrl_rdata;
	logic [15:0]             low_cycles, period_cycles;
	int                      mismatches = 0, checks = 0, cycles = 0;

	i2c_serial_clock_divider uut (.ref_clk(ref_clk), .rst(rst), .enable(enable),
		.ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
		.scl_out(scl_out), .period_pulse(period_pulse), .config_below_min(below_min));
	scl_listener partner (.ref_clk(ref_clk), .rst(rst), .scl(scl_out),
		.low_cycles(low_cycles), .period_cycles(period_cycles));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----
	// shared helpers
	// ----
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wait_pulse;
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (period_pulse !== 1'b1 && n < 5000);
		if (n >= 5000) mismatches++;
		@(posedge ref_clk);
		#1;
	endtask

	// writes config mid-run; the running period must finish on the old setting
	task automatic measure(input logic b, input logic [7:0] m, input string name);
		logic [15:0] lo;
		lo = 16'((m + 1) * (b ? 1 : sclk_div_pkg::PRESCALE_DIV));
		ctrl_wdata = '{b, m};
		ctrl_we = 1'b1;
		@(posedge ref_clk);
		#1 ctrl_we = 1'b0;
		check(16'(ctrl_rdata), {7'h0, b, m});
		check(16'(below_min), 16'(m < sclk_div_pkg::MOD_MIN_I2C));
		wait_pulse();
		wait_pulse();
		repeat (3) @(posedge ref_clk);
		#1;
		check(low_cycles, lo);
		check(period_cycles, 16'(2 * lo + sclk_div_pkg::TAIL_CYC));
		$display("test %s done", name);
	endtask

	// ----
	// scenarios
	// ----
	task automatic test_reset;
		check(16'(ctrl_rdata), {7'h0, sclk_div_pkg::BYPASS_RESET, sclk_div_pkg::MOD_RESET});
		check(16'(scl_out), 16'h1);
		$display("test reset done");
	endtask
	task automatic test_min; measure(1'b1, 8'h02, "min"); endtask
	task automatic test_zero; measure(1'b1, 8'h00, "zero"); endtask
	task automatic test_prescale; measure(1'b0, 8'h01, "prescale"); endtask
	task automatic test_max; measure(1'b0, 8'hff, "max"); endtask

	initial begin
		rst = 1'b1;
		enable = 1'b0;
		ctrl_we = 1'b0;
		ctrl_wdata = '0;
		repeat (8) @(posedge ref_clk);
		#1 rst = 1'b0;
		test_reset();
		enable = 1'b1;
		test_min();
		test_zero();
		test_prescale();
		test_max();
		wrap_up();
	end
endmodule // i2c_serial_clock_divider_tb

`default_nettype wire
